// *** src/trx_state_pkg.sv ***
// package: constants and state type for the transceiver state control block
package trx_state_pkg;
    // operating states
    typedef enum logic [3:0] {
        ST_OFF, ST_WAKEUP, ST_INIT, ST_IDLE, ST_SLEEP, ST_DEEPSLEEP, ST_TX, ST_RX, ST_SNOOZE
    } op_state_e;

    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned RX_SETTLE_NS    = 16_000;      // receiver usable after this
    localparam int unsigned WAKEUP_NS       = 4_000_000;   // oscillator settle before regulator
    localparam int unsigned RESTORE_NS      = 40_000;      // configuration restore and pll lock
    localparam int unsigned NS_PER_S        = 1_000_000_000;
    // receive settle and restore times round up; the wakeup time truncates
    localparam int unsigned RX_SETTLE_CYC   = (RX_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned WAKEUP_CYC      = (WAKEUP_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int unsigned RESTORE_CYC     = (RESTORE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W           = 16;
    localparam logic [31:0] DEEPSLEEP_READ  = 32'hffffffff;  // read data with interface asleep
    localparam int unsigned WAKE_PIN_CYC    = 4;             // wake pin hold time, cycles
    localparam int unsigned RST_SYNC_DEPTH  = 3;
endpackage

// *** src/pin_sync.sv ***
// module: three-stage synchroniser for a pin input
`timescale 1ns/10ps
module pin_sync (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic pin_in,
    output logic      level_out
);
    logic [2:0] stage_r;

    // stage 0 is only read by stage 1; a change counts when stages 1 and 2 agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_r <= 3'h0;
        end else begin
            stage_r <= {stage_r[1:0], pin_in};
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            level_out <= 1'b0;
        end else if (stage_r[1] == stage_r[2]) begin
            level_out <= stage_r[2];
        end
    end
endmodule // pin_sync

// *** src/trx_state_ctrl.sv ***
// module: operating state control of the radio transceiver
`timescale 1ns/10ps
module trx_state_ctrl #(
    parameter int unsigned WAKEUP_CYCLES = trx_state_pkg::WAKEUP_CYC,
    parameter int unsigned CNT_W         = trx_state_pkg::CNT_W
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             power_good,             // leaves off state
    input  wire logic             transceiver_off_cmd,    // set pulse from host
    input  wire logic             tx_start_cmd,
    input  wire logic             tx_done,                // frame sent by transmitter
    input  wire logic             rx_start_cmd,
    input  wire logic             rx_delayed_cmd,
    input  wire logic             rx_late,                // start time already passed
    input  wire logic             wait_for_response,      // auto receive after transmit
    input  wire logic [CNT_W-1:0] response_delay_config,  // cycles before auto receive
    input  wire logic             auto_receive_reenable,
    input  wire logic             ext_rx_gpio6_sel,       // gpio 6 is receive enable
    input  wire logic             ev_preamble,
    input  wire logic             ev_sfd,
    input  wire logic             ev_header,
    input  wire logic             ev_header_err,
    input  wire logic             ev_frame_ready,
    input  wire logic             ev_crc_good,
    input  wire logic             ev_crc_err,
    input  wire logic             ev_rx_timeout,
    input  wire logic             ev_frame_wait_timeout,
    input  wire logic [9:0]       status_clear,           // write one to clear
    input  wire logic             sleep_cmd,
    input  wire logic             deepsleep_cmd,
    input  wire logic [CNT_W-1:0] sleep_count,
    input  wire logic             wake_cnt_en,
    input  wire logic             wake_pin_en,
    input  wire logic             wake_cs_en,
    input  wire logic             wakeup_pin,
    input  wire logic             spi_chip_select_low,
    input  wire logic [31:0]      reg_rdata_in,
    output logic [31:0]           reg_rdata,
    output logic                  transceiver_off_pending,
    output logic [9:0]            system_status_reg,      // 9 late, 8..0 rx events
    output logic [3:0]            op_state,
    output logic                  tx_active,
    output logic                  rx_ready,
    output logic                  external_receive_enable_out,
    output logic                  xtal_enable,
    output logic                  regulator_enable,
    output logic                  reset_output_low,
    output logic                  restore_busy
);
    trx_state_pkg::op_state_e state_r;
    logic [31:0]      cnt_r;
    logic [CNT_W-1:0] sleep_cnt_r;
    logic [2:0]       pin_hold_r;
    logic             cs_lvl, wk_lvl, wk_lvl_d_r, cs_lvl_d_r;
    logic             off_hit, rx_end, wake_evt;
    logic [9:0]       ev_set;

    pin_sync u_cs_sync (.core_clk(core_clk), .rst_b(rst_b), .pin_in(spi_chip_select_low), .level_out(cs_lvl));
    pin_sync u_wk_sync (.core_clk(core_clk), .rst_b(rst_b), .pin_in(wakeup_pin), .level_out(wk_lvl));

    // wake and exit conditions
    assign off_hit  = transceiver_off_cmd || transceiver_off_pending;
    assign rx_end   = ev_crc_good || ev_frame_wait_timeout ||
                      (!auto_receive_reenable && (ev_crc_err || ev_header_err || ev_rx_timeout));
    assign wake_evt = (wake_pin_en && pin_hold_r == 3'(trx_state_pkg::WAKE_PIN_CYC))
                   || (wake_cs_en && cs_lvl_d_r && !cs_lvl);

    // edge history and wake pin hold counter
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wk_lvl_d_r <= 1'b0;
            cs_lvl_d_r <= 1'b0;
            pin_hold_r <= 3'h0;
        end else begin
            wk_lvl_d_r <= wk_lvl;
            cs_lvl_d_r <= cs_lvl;
            if (!wk_lvl) begin
                pin_hold_r <= 3'h0;
            end else if (pin_hold_r != 3'(trx_state_pkg::WAKE_PIN_CYC)) begin
                pin_hold_r <= pin_hold_r + 3'h1;
            end
        end
    end

    // main operating state machine
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r     <= trx_state_pkg::ST_OFF;
            cnt_r       <= 32'h0;
            sleep_cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            case (state_r)
                trx_state_pkg::ST_OFF: begin
                    if (power_good) begin
                        state_r <= trx_state_pkg::ST_WAKEUP;
                        cnt_r   <= 32'h0;
                    end
                end
                trx_state_pkg::ST_WAKEUP: begin
                    if (cnt_r >= WAKEUP_CYCLES - 1) begin
                        state_r <= trx_state_pkg::ST_INIT;
                        cnt_r   <= 32'h0;
                    end
                end
                trx_state_pkg::ST_INIT: begin
                    if (cnt_r >= trx_state_pkg::RESTORE_CYC - 1) begin
                        state_r <= trx_state_pkg::ST_IDLE;
                    end
                end
                trx_state_pkg::ST_IDLE: begin
                    cnt_r <= 32'h0;
                    if (off_hit) begin
                        state_r <= trx_state_pkg::ST_IDLE;
                    end else if (tx_start_cmd) begin
                        state_r <= trx_state_pkg::ST_TX;
                    end else if (rx_start_cmd || (rx_delayed_cmd && !rx_late)) begin
                        state_r <= trx_state_pkg::ST_RX;
                    end else if (sleep_cmd) begin
                        state_r     <= trx_state_pkg::ST_SLEEP;
                        sleep_cnt_r <= sleep_count;
                    end else if (deepsleep_cmd) begin
                        state_r <= trx_state_pkg::ST_DEEPSLEEP;
                    end
                end
                trx_state_pkg::ST_TX: begin
                    if (off_hit) begin
                        state_r <= trx_state_pkg::ST_IDLE;
                    end else if (tx_done && wait_for_response) begin
                        state_r     <= trx_state_pkg::ST_SNOOZE;
                        sleep_cnt_r <= response_delay_config;
                    end else if (tx_done) begin
                        state_r <= trx_state_pkg::ST_IDLE;
                    end
                end
                trx_state_pkg::ST_SNOOZE: begin
                    if (off_hit) begin
                        state_r <= trx_state_pkg::ST_IDLE;
                    end else if (sleep_cnt_r == '0) begin
                        state_r <= trx_state_pkg::ST_RX;
                        cnt_r   <= 32'h0;
                    end else begin
                        sleep_cnt_r <= sleep_cnt_r - 1'b1;
                    end
                end
                trx_state_pkg::ST_RX: begin
                    if (off_hit || rx_end) begin
                        state_r <= trx_state_pkg::ST_IDLE;
                    end
                end
                trx_state_pkg::ST_SLEEP: begin
                    cnt_r <= 32'h0;
                    if (wake_evt || (wake_cnt_en && sleep_cnt_r == '0)) begin
                        state_r <= trx_state_pkg::ST_WAKEUP;
                    end else if (sleep_cnt_r != '0) begin
                        sleep_cnt_r <= sleep_cnt_r - 1'b1;
                    end
                end
                trx_state_pkg::ST_DEEPSLEEP: begin
                    cnt_r <= 32'h0;
                    if (wake_evt) begin
                        state_r <= trx_state_pkg::ST_WAKEUP;
                    end
                end
                default: state_r <= trx_state_pkg::ST_OFF;
            endcase
        end
    end

    // off command latch; set from host, cleared once acted on
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            transceiver_off_pending <= 1'b0;
        end else begin
            transceiver_off_pending <= transceiver_off_cmd &&
                !(state_r inside {trx_state_pkg::ST_IDLE, trx_state_pkg::ST_TX,
                                  trx_state_pkg::ST_RX, trx_state_pkg::ST_SNOOZE}) ? 1'b1 :
                (off_hit && !(state_r inside {trx_state_pkg::ST_IDLE, trx_state_pkg::ST_TX,
                                  trx_state_pkg::ST_RX, trx_state_pkg::ST_SNOOZE}));
        end
    end

    // sticky status flags, set wins over clear
    assign ev_set = {
        (state_r == trx_state_pkg::ST_IDLE) && rx_delayed_cmd && rx_late && !off_hit,
        ev_frame_wait_timeout,
        ev_rx_timeout && !auto_receive_reenable,
        ev_crc_err && !auto_receive_reenable,
        ev_crc_good, ev_frame_ready,
        ev_header_err && !auto_receive_reenable,
        ev_header, ev_sfd, ev_preamble};
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            system_status_reg <= 10'h0;
        end else begin
            // receive events count only in receive; the late warning only in idle
            for (int i = 0; i < 10; i++) begin
                if (ev_set[i] && (i == 9 || state_r == trx_state_pkg::ST_RX)) begin
                    system_status_reg[i] <= 1'b1;
                end else if (status_clear[i]) begin
                    system_status_reg[i] <= 1'b0;
                end
            end
        end
    end

    // registered outputs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            op_state                    <= 4'h0;
            tx_active                   <= 1'b0;
            rx_ready                    <= 1'b0;
            external_receive_enable_out <= 1'b0;
            xtal_enable                 <= 1'b0;
            regulator_enable            <= 1'b0;
            reset_output_low            <= 1'b0;
            restore_busy                <= 1'b0;
            reg_rdata                   <= 32'h0;
        end else begin
            op_state  <= 4'(state_r);
            tx_active <= (state_r == trx_state_pkg::ST_TX);
            rx_ready  <= (state_r == trx_state_pkg::ST_RX) &&
                         (cnt_r >= trx_state_pkg::RX_SETTLE_CYC);
            external_receive_enable_out <= ext_rx_gpio6_sel && (state_r == trx_state_pkg::ST_RX);
            xtal_enable      <= !(state_r inside {trx_state_pkg::ST_OFF, trx_state_pkg::ST_SLEEP,
                                                  trx_state_pkg::ST_DEEPSLEEP});
            regulator_enable <= !(state_r inside {trx_state_pkg::ST_OFF, trx_state_pkg::ST_SLEEP,
                                                  trx_state_pkg::ST_DEEPSLEEP, trx_state_pkg::ST_WAKEUP});
            reset_output_low <= !(state_r inside {trx_state_pkg::ST_OFF, trx_state_pkg::ST_SLEEP,
                                                  trx_state_pkg::ST_DEEPSLEEP, trx_state_pkg::ST_WAKEUP});
            restore_busy     <= (state_r == trx_state_pkg::ST_INIT);
            reg_rdata <= (state_r inside {trx_state_pkg::ST_DEEPSLEEP, trx_state_pkg::ST_SLEEP})
                         ? trx_state_pkg::DEEPSLEEP_READ : reg_rdata_in;
        end
    end

    // checks
    AST_OFF_TX: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == trx_state_pkg::ST_TX && transceiver_off_cmd) |=> state_r == trx_state_pkg::ST_IDLE)
        else $error("off command did not stop transmit");
    AST_OFF_RX: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == trx_state_pkg::ST_RX && transceiver_off_cmd) |=> state_r == trx_state_pkg::ST_IDLE)
        else $error("off command did not stop receive");
    AST_OFF_CLR: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == trx_state_pkg::ST_IDLE) |=> !transceiver_off_pending)
        else $error("off bit not cleared");
    AST_RX_SETTLE: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(state_r == trx_state_pkg::ST_RX) |-> !rx_ready [*8])
        else $error("receiver ready too early");
    AST_LATE: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == trx_state_pkg::ST_IDLE && rx_delayed_cmd && rx_late && !off_hit) |=> system_status_reg[9])
        else $error("late warning missing");
    AST_RX_END: assert property (@(posedge core_clk) disable iff (!rst_b)
        (state_r == trx_state_pkg::ST_RX && ev_crc_good) |=> state_r == trx_state_pkg::ST_IDLE)
        else $error("receive did not end on good frame");
    AST_AUTOR: assert property (@(posedge core_clk) disable iff (!rst_b)
        (auto_receive_reenable && !$past(system_status_reg[6]) && !status_clear[6]) |=> !$rose(system_status_reg[6]))
        else $error("error flag raised under auto re-enable");
    AST_GPIO6: assert property (@(posedge core_clk) disable iff (!rst_b)
        external_receive_enable_out |-> $past(state_r == trx_state_pkg::ST_RX))
        else $error("receive enable pin high outside receive");
    AST_DIR: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(tx_active && external_receive_enable_out))
        else $error("transmit and receive together");
    AST_DEEP_READ: assert property (@(posedge core_clk) disable iff (!rst_b)
        $past(state_r == trx_state_pkg::ST_DEEPSLEEP) |-> reg_rdata == 32'hffffffff)
        else $error("deep sleep read not all ones");
    COV_AUTO_RX: cover property (@(posedge core_clk) disable iff (!rst_b)
        state_r == trx_state_pkg::ST_SNOOZE ##1 state_r == trx_state_pkg::ST_RX);
    COV_WAKE: cover property (@(posedge core_clk) disable iff (!rst_b)
        state_r == trx_state_pkg::ST_DEEPSLEEP ##1 state_r == trx_state_pkg::ST_WAKEUP);
    COV_OFF_RX: cover property (@(posedge core_clk) disable iff (!rst_b)
        state_r == trx_state_pkg::ST_RX && transceiver_off_cmd);
endmodule // trx_state_ctrl

// *** testbench/host_pins.sv ***
// host model: drives chip select and wake pin toward the device
`timescale 1ns/10ps
module host_pins (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic restore_busy,
    input  wire logic cs_go,
    input  wire logic wake_go,
    output logic      spi_chip_select_low,
    output logic      wakeup_pin
);
    logic [3:0] cs_cnt_r;
    logic [3:0] wk_cnt_r;
    // host holds off access during restore; pins held for eight cycles
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_cnt_r <= 4'h0;
            wk_cnt_r <= 4'h0;
        end else begin
            if (cs_go && !restore_busy) cs_cnt_r <= 4'h8;
            else if (cs_cnt_r != 4'h0) cs_cnt_r <= cs_cnt_r - 4'h1;
            if (wake_go) wk_cnt_r <= 4'h8;
            else if (wk_cnt_r != 4'h0) wk_cnt_r <= wk_cnt_r - 4'h1;
        end
    end
    // idle chip select is high, wake pin low
    assign spi_chip_select_low = (cs_cnt_r == 4'h0);
    assign wakeup_pin          = (wk_cnt_r != 4'h0);
endmodule // host_pins

// *** testbench/tb.sv ***
// testbench for the transceiver state control block
`timescale 1ns/10ps
module tb;
    logic core_clk = 1'b0, rst_b = 1'b0, power_good = 1'b0, off_c = 1'b0, tx_c = 1'b0, tx_done = 1'b0;
    logic rx_c = 1'b0, rxd_c = 1'b0, rx_late = 1'b0, wfr = 1'b0, autor = 1'b0, gsel = 1'b1;
    logic slp_c = 1'b0, dslp_c = 1'b0, wcnt = 1'b0, wpin = 1'b0, wcs = 1'b0, cs_go = 1'b0, wake_go = 1'b0;
    logic [8:0]  ev = 9'h0;
    logic [9:0]  status_clear = 10'h0;
    logic [15:0] rdc = 16'h5, scnt = 16'ha;
    logic [31:0] rdi = 32'h1234_abcd, rdo;
    logic [9:0]  status;
    logic [3:0]  op_state;
    logic        pend, tx_active, rx_ready, ext_rx, xtal, regu, rst_out, rbusy, cs_l, wk;
    int          miscompares = 0, checked = 0, n;

    always #50 core_clk = ~core_clk;

    host_pins hp (.core_clk(core_clk), .rst_b(rst_b), .restore_busy(rbusy), .cs_go(cs_go), .wake_go(wake_go),
                  .spi_chip_select_low(cs_l), .wakeup_pin(wk));
    trx_state_ctrl #(.WAKEUP_CYCLES(20), .CNT_W(16)) uut (
        .core_clk(core_clk), .rst_b(rst_b), .power_good(power_good), .transceiver_off_cmd(off_c),
        .tx_start_cmd(tx_c), .tx_done(tx_done), .rx_start_cmd(rx_c), .rx_delayed_cmd(rxd_c),
        .rx_late(rx_late), .wait_for_response(wfr), .response_delay_config(rdc),
        .auto_receive_reenable(autor), .ext_rx_gpio6_sel(gsel), .ev_preamble(ev[0]), .ev_sfd(ev[1]),
        .ev_header(ev[2]), .ev_header_err(ev[3]), .ev_frame_ready(ev[4]), .ev_crc_good(ev[5]),
        .ev_crc_err(ev[6]), .ev_rx_timeout(ev[7]), .ev_frame_wait_timeout(ev[8]),
        .status_clear(status_clear), .sleep_cmd(slp_c), .deepsleep_cmd(dslp_c), .sleep_count(scnt),
        .wake_cnt_en(wcnt), .wake_pin_en(wpin), .wake_cs_en(wcs), .wakeup_pin(wk),
        .spi_chip_select_low(cs_l), .reg_rdata_in(rdi), .reg_rdata(rdo), .transceiver_off_pending(pend),
        .system_status_reg(status), .op_state(op_state), .tx_active(tx_active), .rx_ready(rx_ready),
        .external_receive_enable_out(ext_rx), .xtal_enable(xtal), .regulator_enable(regu),
        .reset_output_low(rst_out), .restore_busy(rbusy));

    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one-cycle pulse, called at a falling edge
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge core_clk);
        s = 1'b0;
    endtask

    task automatic evp(int i);
        ev[i] = 1'b1;
        @(negedge core_clk);
        ev = 9'h0;
        @(negedge core_clk);
    endtask

    // bounded wait for a state, then compare
    task automatic wait_st(trx_state_pkg::op_state_e st, int lim);
        for (n = 0; n < lim && op_state !== 4'(st); n++) @(negedge core_clk);
        chk("op_state", op_state, 32'(st));
    endtask

    task automatic clr();
        status_clear = 10'h3ff;
        @(negedge core_clk);
        status_clear = 10'h0;
    endtask

    task automatic boot();
        wait_st(trx_state_pkg::ST_WAKEUP, 10);
        @(negedge core_clk);
        chk("xtal", {xtal, regu, rst_out}, 32'h4);
        wait_st(trx_state_pkg::ST_INIT, 30);
        @(negedge core_clk);
        chk("init_out", {rst_out, rbusy}, 32'h3);
        wait_st(trx_state_pkg::ST_IDLE, trx_state_pkg::RESTORE_CYC + 10);
        @(negedge core_clk);
        chk("restore_busy", rbusy, 32'h0);
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (8) @(negedge core_clk);
        chk("reset_out", {op_state, xtal, rst_out}, 32'h0);
        rst_b = 1'b1;
        power_good = 1'b1;
        boot();
        chk("rdata", rdo, rdi);
        // immediate receive with settle time and status events
        pulse(rx_c);
        wait_st(trx_state_pkg::ST_RX, 5);
        @(negedge core_clk);
        chk("ext_rx", {ext_rx, rx_ready, tx_active}, 32'h4);
        for (n = 0; n < 200 && rx_ready !== 1'b1; n++) @(negedge core_clk);
        chk("rx_settle", 32'(n >= trx_state_pkg::RX_SETTLE_CYC - 4 && n <= trx_state_pkg::RX_SETTLE_CYC), 1);
        for (int i = 0; i < 5; i++) if (i != 3) evp(i);
        chk("status_rx", status, 32'h17);
        evp(5);
        wait_st(trx_state_pkg::ST_IDLE, 3);
        @(negedge core_clk);
        chk("crc_good", {status[5], ext_rx}, 32'h2);
        clr();
        // auto re-enable masks errors and receive timeout, not frame-wait timeout; auto re-enable set before enable
        autor = 1'b1;
        pulse(rx_c);
        wait_st(trx_state_pkg::ST_RX, 5);
        evp(3);
        evp(6);
        evp(7);
        chk("masked", {op_state, status}, {18'h0, 4'h7, 10'h0});
        evp(8);
        wait_st(trx_state_pkg::ST_IDLE, 3);
        chk("fwto", status, 32'h100);
        clr();
        autor = 1'b0;
        for (int i = 3; i < 8; i++) begin
            if (i == 4 || i == 5) continue;
            pulse(rx_c);
            wait_st(trx_state_pkg::ST_RX, 5);
            evp(i);
            wait_st(trx_state_pkg::ST_IDLE, 3);
            chk("rx_err", status, 32'(1 << i));
            clr();
        end
        // off command aborts receive, transmit, and does nothing in idle
        pulse(rx_c);
        wait_st(trx_state_pkg::ST_RX, 5);
        pulse(off_c);
        wait_st(trx_state_pkg::ST_IDLE, 3);
        pulse(tx_c);
        wait_st(trx_state_pkg::ST_TX, 5);
        @(negedge core_clk);
        pulse(rx_c);
        chk("tx_only", {tx_active, ext_rx, op_state}, 32'h26);
        pulse(off_c);
        wait_st(trx_state_pkg::ST_IDLE, 3);
        @(negedge core_clk);
        chk("tx_off", {tx_active, pend}, 32'h0);
        pulse(off_c);
        repeat (3) @(negedge core_clk);
        chk("idle_off", {pend, op_state}, 32'h3);
        // delayed receive: late then on time; start time set before command
        rx_late = 1'b1;
        pulse(rxd_c);
        rx_late = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("late", {status, op_state}, {10'h200, 4'h3});
        clr();
        pulse(rxd_c);
        wait_st(trx_state_pkg::ST_RX, 5);
        pulse(off_c);
        wait_st(trx_state_pkg::ST_IDLE, 3);
        // auto receive after transmit through the response delay
        wfr = 1'b1;
        pulse(tx_c);
        wait_st(trx_state_pkg::ST_TX, 5);
        pulse(tx_done);
        wait_st(trx_state_pkg::ST_SNOOZE, 3);
        wait_st(trx_state_pkg::ST_RX, 32'(rdc) + 3);
        chk("snooze_len", 32'(n >= 32'(rdc) - 1), 1);
        wfr = 1'b0;
        pulse(off_c);
        wait_st(trx_state_pkg::ST_IDLE, 3);
        // sleep counter wake
        wcnt = 1'b1;
        pulse(slp_c);
        wait_st(trx_state_pkg::ST_SLEEP, 5);
        @(negedge core_clk);
        chk("sleep_rd", rdo, trx_state_pkg::DEEPSLEEP_READ);
        boot();
        wcnt = 1'b0;
        // deep sleep, then wake pin and chip select wakes
        wpin = 1'b1;
        pulse(dslp_c);
        wait_st(trx_state_pkg::ST_DEEPSLEEP, 5);
        repeat (40) @(negedge core_clk);
        chk("deep_rd", rdo, trx_state_pkg::DEEPSLEEP_READ);
        chk("deep", op_state, 32'h5);
        pulse(wake_go);
        boot();
        wpin = 1'b0;
        wcs = 1'b1;
        pulse(dslp_c);
        wait_st(trx_state_pkg::ST_DEEPSLEEP, 5);
        pulse(cs_go);
        boot();
        stop_test();
    end
endmodule // tb
